/* File: include/dtp_pkg.sv */
// constants shared by the down timer, pwm, buzzer and carrier block
package dtp_pkg;
  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_TIMER_COUNT_RELOAD = 3'h0;
  localparam logic [2:0] IDX_TIMER_CONTROL_ONE = 3'h1;
  localparam logic [2:0] IDX_TIMER_CONTROL_TWO = 3'h2;
  localparam logic [2:0] IDX_PWM_DUTY_COMPARE = 3'h3;
  localparam logic [2:0] IDX_PRESCALER_COUNT_VALUE = 3'h4;
  localparam logic [2:0] IDX_BUZZER_CONTROL = 3'h5;
  localparam logic [2:0] IDX_CARRIER_CONTROL = 3'h6;
  localparam int ADDR_W = 5;
  localparam int IDX_LSB = 2;

  // timer_control_one fields
  localparam int C1_TIMER_RUN = 0;
  localparam int C1_RELOAD_SELECT = 1;
  localparam int C1_ONE_SHOT_SELECT = 2;
  localparam int C1_HIGH_FREQ_CLOCK_SELECT = 3;
  localparam int C1_PWM_ACTIVE_LOW = 6;
  localparam int C1_PWM_OUTPUT_ENABLE = 7;
  localparam logic [7:0] C1_MASK = 8'hCF;
  localparam logic [7:0] C1_RESET = 8'h00;

  // timer_control_two fields
  localparam int C2_RATE_LSB = 0;
  localparam int C2_PRESCALER_DISABLE_N = 3;
  localparam int C2_EXTERNAL_EDGE_SELECT = 4;
  localparam int C2_CLOCK_SOURCE_SELECT = 5;
  localparam logic [7:0] C2_MASK = 8'h3F;
  localparam logic [7:0] C2_RESET = 8'h3F;

  // buzzer_control fields
  localparam int BZ_CODE_LSB = 0;
  localparam int BZ_ENABLE = 7;
  localparam logic [7:0] BZ_MASK = 8'h8F;
  localparam logic [7:0] BZ_RESET = 8'h0F;

  // carrier_control fields
  localparam int IR_ENABLE = 0;
  localparam int IR_FREQUENCY_SELECT = 1;
  localparam int IR_POLARITY_SELECT = 2;
  localparam int IR_CRYSTAL_TYPE_SELECT = 7;
  localparam logic [7:0] IR_MASK = 8'h87;
  localparam logic [7:0] IR_RESET = 8'h00;

  // counter values
  localparam logic [7:0] TIMER_TOP = 8'hFF;
  localparam logic [7:0] TIMER_ZERO = 8'h00;
  localparam logic [7:0] PRESCALER_RESET = 8'hFF;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // carrier division from the 4 MHz high oscillator tick
  localparam int HIRC_DIV_57K = 64;
  localparam int HIRC_DIV_38K = 96;
endpackage : dtp_pkg

/* File: logic/dtp_timer.sv */
// 8-bit down timer with prescaler, pwm, buzzer and ir carrier behind an avalon-mm slave
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - reading the count register returns the live down counter value.
// - writing the count register loads both reload holding register and live counter.
// - run bit one counts down; zero halts the counter.
// - non-stop, reload select zero: underflow loads 0xFF and counting continues.
// - non-stop, reload select one: underflow loads stored reload value, continues.
// - one-shot: count down to 0x00, stop at underflow regardless of reload select.
// - high-frequency select picks high oscillator tick, else cpu clock tick.
// - clock source select picks external pin, else instruction clock.
// - edge select one counts falling pin edges, zero counts rising edges.
// - prescaler bypassed while its disable bit is one, used while zero.
// - prescaler rate code divides by two to the power code plus one.
// - prescaler count register reads live prescaler counter; writes ignored.
// - pwm inactive after start, active from duty match until underflow.
// - pwm period comes from reload value, duty from duty compare register.
// - pwm enable routes pwm to pin; polarity bit one makes active level low.
// - buzzer codes 0-7 give prescaler divided 1:2 to 1:256.
// - buzzer codes 8-15 give timer counter bit 0 to 7.
// - carrier enable bit turns the ir carrier output on or off.
// - carrier frequency bit one selects 57 kHz, zero 38 kHz.
// - polarity zero emits carrier on pin data 1, one emits on 0.
// - crystal type picks 3.58 MHz or 455 kHz division with external crystal only.
// - internal high oscillator: 4 MHz divided by 64 or 96.
module dtp_timer
  import dtp_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int XTAL358_DIV_57K = 62,
  parameter int XTAL358_DIV_38K = 94,
  parameter int XTAL455_DIV_57K = 8,
  parameter int XTAL455_DIV_38K = 12
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest,
  // clock event ticks, one cycle each, and the external crystal level
  input wire logic instr_tick,
  input wire logic cpu_tick,
  input wire logic hosc_tick,
  input wire logic external_crystal,
  // pins
  input wire logic external_clock_pin,
  input wire logic ir_pin_data,
  output logic pwm_out,
  output logic pwm_pin_select,
  output logic buzzer_out,
  output logic carrier_out
);

  localparam int HALF_W = 8;
  localparam int DIV_MAX = 2 * (2 ** HALF_W) - 1;

  // parameter values that the logic cannot serve are refused at elaboration
  if (CNT_W != 8)
  begin : g_width_check
    $error("dtp_timer supports only an 8-bit counter");
  end
  if (XTAL358_DIV_57K < 2 || XTAL358_DIV_38K < 2 || XTAL455_DIV_57K < 2 || XTAL455_DIV_38K < 2)
  begin : g_div_low_check
    $error("dtp_timer carrier divisors must be at least two");
  end
  if (XTAL358_DIV_57K > DIV_MAX || XTAL358_DIV_38K > DIV_MAX
      || XTAL455_DIV_57K > DIV_MAX || XTAL455_DIV_38K > DIV_MAX)
  begin : g_div_high_check
    $error("dtp_timer carrier divisors must fit the half-period counter");
  end

  localparam logic [HALF_W-1:0] HALF_H57 = HALF_W'(HIRC_DIV_57K / 2);
  localparam logic [HALF_W-1:0] HALF_H38 = HALF_W'(HIRC_DIV_38K / 2);
  localparam logic [HALF_W-1:0] HALF_X357 = HALF_W'(XTAL358_DIV_57K / 2);
  localparam logic [HALF_W-1:0] HALF_X338 = HALF_W'(XTAL358_DIV_38K / 2);
  localparam logic [HALF_W-1:0] HALF_X457 = HALF_W'(XTAL455_DIV_57K / 2);
  localparam logic [HALF_W-1:0] HALF_X438 = HALF_W'(XTAL455_DIV_38K / 2);

  // registers
  logic [7:0] timer_count;
  logic [7:0] reload_value;
  logic [7:0] timer_control_one;
  logic [7:0] timer_control_two;
  logic [7:0] pwm_duty_compare;
  logic [7:0] prescaler_count;
  logic [7:0] buzzer_control;
  logic [7:0] carrier_control;
  logic one_shot_done;
  logic pwm_active;
  logic ext_pin_q;
  logic [HALF_W-1:0] carrier_count;
  logic carrier_wave;

  // bus decode
  logic [2:0] bus_index;
  logic bus_write_taken;
  logic write_count;

  assign bus_index = avs_address[IDX_LSB+2:IDX_LSB];
  assign bus_write_taken = avs_write && !avs_waitrequest;
  assign write_count = bus_write_taken && bus_index == IDX_TIMER_COUNT_RELOAD;

  function automatic logic wr_hit(input logic [2:0] idx);
    wr_hit = bus_write_taken && bus_index == idx;
  endfunction

  // control fields
  logic timer_run;
  logic reload_select;
  logic one_shot_select;
  logic high_freq_clock_select;
  logic pwm_active_low;
  logic pwm_output_enable;
  logic [2:0] prescaler_rate_field;
  logic prescaler_disable_n;
  logic external_edge_select;
  logic clock_source_select;
  logic [3:0] buzzer_frequency_code;
  logic buzzer_enable;
  logic carrier_enable;
  logic carrier_frequency_select;
  logic carrier_polarity_select;
  logic crystal_type_select;

  assign timer_run = timer_control_one[C1_TIMER_RUN];
  assign reload_select = timer_control_one[C1_RELOAD_SELECT];
  assign one_shot_select = timer_control_one[C1_ONE_SHOT_SELECT];
  assign high_freq_clock_select = timer_control_one[C1_HIGH_FREQ_CLOCK_SELECT];
  assign pwm_active_low = timer_control_one[C1_PWM_ACTIVE_LOW];
  assign pwm_output_enable = timer_control_one[C1_PWM_OUTPUT_ENABLE];
  assign prescaler_rate_field = timer_control_two[C2_RATE_LSB +: 3];
  assign prescaler_disable_n = timer_control_two[C2_PRESCALER_DISABLE_N];
  assign external_edge_select = timer_control_two[C2_EXTERNAL_EDGE_SELECT];
  assign clock_source_select = timer_control_two[C2_CLOCK_SOURCE_SELECT];
  assign buzzer_frequency_code = buzzer_control[BZ_CODE_LSB +: 4];
  assign buzzer_enable = buzzer_control[BZ_ENABLE];
  assign carrier_enable = carrier_control[IR_ENABLE];
  assign carrier_frequency_select = carrier_control[IR_FREQUENCY_SELECT];
  assign carrier_polarity_select = carrier_control[IR_POLARITY_SELECT];
  assign crystal_type_select = carrier_control[IR_CRYSTAL_TYPE_SELECT];

  // avalon handshake: one wait cycle, then a single ready cycle
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      avs_waitrequest <= 1'b1;
    else if (avs_waitrequest && (avs_read || avs_write))
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  // read data, captured in the wait cycle; write-only and unmapped read zero
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      avs_readdata <= DATA_RESET;
    else if (avs_read && avs_waitrequest)
    begin
      case (bus_index)
        IDX_TIMER_COUNT_RELOAD: avs_readdata <= timer_count;
        IDX_TIMER_CONTROL_ONE: avs_readdata <= timer_control_one;
        IDX_TIMER_CONTROL_TWO: avs_readdata <= timer_control_two;
        IDX_PRESCALER_COUNT_VALUE: avs_readdata <= prescaler_count;
        default: avs_readdata <= DATA_RESET;
      endcase
    end
  end

  // software-written registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      timer_control_one <= C1_RESET;
      timer_control_two <= C2_RESET;
      pwm_duty_compare <= DATA_RESET;
      buzzer_control <= BZ_RESET;
      carrier_control <= IR_RESET;
      reload_value <= DATA_RESET;
    end
    else
    begin
      if (wr_hit(IDX_TIMER_COUNT_RELOAD))
        reload_value <= avs_writedata;
      if (wr_hit(IDX_TIMER_CONTROL_ONE))
        timer_control_one <= avs_writedata & C1_MASK;
      if (wr_hit(IDX_TIMER_CONTROL_TWO))
        timer_control_two <= avs_writedata & C2_MASK;
      if (wr_hit(IDX_PWM_DUTY_COMPARE))
        pwm_duty_compare <= avs_writedata;
      if (wr_hit(IDX_BUZZER_CONTROL))
        buzzer_control <= avs_writedata & BZ_MASK;
      if (wr_hit(IDX_CARRIER_CONTROL))
        carrier_control <= avs_writedata & IR_MASK;
    end
  end

  // clock source selection
  logic ext_rise;
  logic ext_fall;
  logic ext_event;
  logic int_event;
  logic source_event;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ext_pin_q <= 1'b0;
    else
      ext_pin_q <= external_clock_pin;
  end

  assign ext_rise = external_clock_pin && !ext_pin_q;
  assign ext_fall = !external_clock_pin && ext_pin_q;
  assign ext_event = external_edge_select ? ext_fall : ext_rise;
  assign int_event = high_freq_clock_select ? hosc_tick : cpu_tick;
  // the internal choice is gated by the instruction clock tick when the pin is not used
  assign source_event = clock_source_select ? ext_event
                                            : (instr_tick && int_event);

  // prescaler: free down counter, one output pulse per 2^(code+1) events
  logic [7:0] rate_mask;
  logic prescale_pulse;
  logic count_event;

  // ones in the low code+1 bits: masked value is zero once per 2^(code+1) events
  assign rate_mask = 8'((9'h002 << prescaler_rate_field) - 9'h001);
  assign prescale_pulse = source_event && ((prescaler_count & rate_mask) == TIMER_ZERO);
  assign count_event = prescaler_disable_n ? source_event : prescale_pulse;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      prescaler_count <= PRESCALER_RESET;
    else if (source_event)
      prescaler_count <= prescaler_count - 8'h01;
  end

  // down counter
  logic underflow;
  logic counting;

  assign counting = timer_run && !one_shot_done && count_event;
  // underflow is a count event seen while the counter already holds zero
  assign underflow = counting && timer_count == TIMER_ZERO;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      timer_count <= DATA_RESET;
    else if (write_count)
      timer_count <= avs_writedata;
    else if (underflow)
    begin
      if (one_shot_select)
        timer_count <= TIMER_ZERO;
      else if (reload_select)
        timer_count <= reload_value;
      else
        timer_count <= TIMER_TOP;
    end
    else if (counting)
      timer_count <= timer_count - 8'h01;
  end

  // one-shot stop flag, cleared by a new count or a restart
  // a stop in the same cycle as a restart wins
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      one_shot_done <= 1'b0;
    else if (underflow && one_shot_select)
      one_shot_done <= 1'b1;
    else if (write_count || !timer_run)
      one_shot_done <= 1'b0;
  end

  // pwm: active from duty match until underflow
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pwm_active <= 1'b0;
    else if (!timer_run || underflow || write_count)
      pwm_active <= 1'b0;
    else if (timer_count == pwm_duty_compare)
      pwm_active <= 1'b1;
  end

  // pin-side copies, registered so every output leaves a flip-flop
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pwm_out <= 1'b0;
      pwm_pin_select <= 1'b0;
    end
    else
    begin
      pwm_out <= pwm_active ^ pwm_active_low;
      pwm_pin_select <= pwm_output_enable;
    end
  end

  // buzzer: prescaler bit for low codes, timer bit for high codes
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      buzzer_out <= 1'b0;
    else if (!buzzer_enable)
      buzzer_out <= 1'b0;
    else if (buzzer_frequency_code[3])
      buzzer_out <= timer_count[buzzer_frequency_code[2:0]];
    else
      buzzer_out <= !prescaler_count[buzzer_frequency_code[2:0]];
  end

  // ir carrier: half-period counter on the high oscillator tick
  logic [HALF_W-1:0] carrier_half;

  always_comb
  begin
    if (!external_crystal)
      carrier_half = carrier_frequency_select ? HALF_H57 : HALF_H38;
    else if (crystal_type_select)
      carrier_half = carrier_frequency_select ? HALF_X357 : HALF_X338;
    else
      carrier_half = carrier_frequency_select ? HALF_X457 : HALF_X438;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      carrier_count <= '0;
      carrier_wave <= 1'b0;
    end
    else if (!carrier_enable)
    begin
      carrier_count <= '0;
      carrier_wave <= 1'b0;
    end
    else if (hosc_tick)
    begin
      if (carrier_count >= carrier_half - HALF_W'(1))
      begin
        carrier_count <= '0;
        carrier_wave <= !carrier_wave;
      end
      else
        carrier_count <= carrier_count + HALF_W'(1);
    end
  end

  // gated by pin data; polarity select inverts which level emits
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      carrier_out <= 1'b0;
    else
      carrier_out <= carrier_enable && carrier_wave
                     && (ir_pin_data ^ carrier_polarity_select);
  end

endmodule // dtp_timer
`default_nettype wire

/* File: sim/dtp_load_model.sv */
// clock sources and external clock pin driving the timer
`timescale 1ns/10ps
`default_nettype none
module dtp_load_model
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // control from the bench
  input wire logic gen,
  input wire logic pin_en,
  // sources
  output logic instr_tick,
  output logic cpu_tick,
  output logic hosc_tick,
  output logic external_clock_pin
);
  // high oscillator ticks every other cycle, pin toggles once per cycle
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      instr_tick <= 1'b0;
      cpu_tick <= 1'b0;
      hosc_tick <= 1'b0;
      external_clock_pin <= 1'b0;
    end
    else
    begin
      instr_tick <= gen;
      cpu_tick <= gen;
      hosc_tick <= gen & ~hosc_tick;
      external_clock_pin <= external_clock_pin ^ (gen & pin_en);
    end
  end
endmodule // dtp_load_model
`default_nettype wire

/* File: sim/dtp_timer_chk.sv */
// checker for the timer block bus handshake and output gating
`timescale 1ns/10ps
`default_nettype none
module dtp_timer_chk
  import dtp_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  input wire logic [7:0] avs_readdata,
  input wire logic avs_waitrequest,
  // outputs
  input wire logic pwm_pin_select,
  input wire logic buzzer_out,
  input wire logic carrier_out
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  logic [2:0] idx;
  logic wdone;
  assign idx = avs_address[4:2];
  assign wdone = avs_write && !avs_waitrequest;

  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  a_wo_reads_zero: assert property (avs_read && !avs_waitrequest && (idx == IDX_PWM_DUTY_COMPARE
    || idx == IDX_BUZZER_CONTROL || idx >= IDX_CARRIER_CONTROL) |-> avs_readdata == DATA_RESET)
    else $error("write-only or unmapped read not zero");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_pin_route: assert property (wdone && idx == IDX_TIMER_CONTROL_ONE
    && avs_writedata[C1_PWM_OUTPUT_ENABLE] |-> ##[1:2] pwm_pin_select)
    else $error("pwm pin not routed after enable");
  a_buzz_off: assert property (wdone && idx == IDX_BUZZER_CONTROL
    && !avs_writedata[BZ_ENABLE] |-> ##2 !buzzer_out)
    else $error("buzzer active while disabled");
  a_carrier_off: assert property (wdone && idx == IDX_CARRIER_CONTROL
    && !avs_writedata[IR_ENABLE] |-> ##2 !carrier_out)
    else $error("carrier active while disabled");

  c_read: cover property (avs_read && !avs_waitrequest);
  c_write: cover property (wdone);
  c_carrier: cover property (carrier_out);
endmodule // dtp_timer_chk

bind dtp_timer dtp_timer_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pwm_pin_select(pwm_pin_select),
  .buzzer_out(buzzer_out), .carrier_out(carrier_out));
`default_nettype wire

/* File: sim/dtp_timer_tb.sv */
// testbench for the down timer, pwm, buzzer and carrier block
`timescale 1ns/10ps
`default_nettype none
module dtp_timer_tb
  import dtp_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_writedata = 8'h00;
  logic gen = 1'b0;
  logic pin_en = 1'b0;
  logic ir_pin_data = 1'b0;
  logic xtal = 1'b0;
  logic mon_sel = 1'b0;
  logic clr = 1'b0;
  logic [7:0] avs_readdata, rdv;
  logic avs_waitrequest, instr_tick, cpu_tick, hosc_tick, external_clock_pin;
  logic pwm_out, pwm_pin_select, buzzer_out, carrier_out, mon, mon_d;
  int errors = 0;
  int cmp_count = 0;
  int togs = 0;
  logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h3F, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
  logic [7:0] irc[7] = '{8'h03, 8'h01, 8'h03, 8'h07, 8'h02, 8'h83, 8'h03};
  logic ipd[7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  int irn[7] = '{256, 384, 256, 256, 256, 248, 32};
  logic [7:0] ire[7] = '{8'h04, 8'h04, 8'h00, 8'h04, 8'h00, 8'h04, 8'h04};
  logic xtl[7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

  always #5 core_clk = ~core_clk;
  assign mon = mon_sel ? carrier_out : buzzer_out;
  always @(posedge core_clk)
  begin
    mon_d <= mon;
    togs <= clr ? 0 : togs + int'(mon !== mon_d);
  end

  dtp_timer uut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .instr_tick(instr_tick), .cpu_tick(cpu_tick), .hosc_tick(hosc_tick),
    .external_crystal(xtal), .external_clock_pin(external_clock_pin),
    .ir_pin_data(ir_pin_data), .pwm_out(pwm_out), .pwm_pin_select(pwm_pin_select),
    .buzzer_out(buzzer_out), .carrier_out(carrier_out));
  dtp_load_model u_load (.core_clk(core_clk), .sys_rst(sys_rst), .gen(gen),
    .pin_en(pin_en), .instr_tick(instr_tick), .cpu_tick(cpu_tick),
    .hosc_tick(hosc_tick), .external_clock_pin(external_clock_pin));

  task automatic give_verdict();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    avs_address <= {i, 2'b00};
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rc(input logic [2:0] i, input logic [7:0] exp);
    avs_address <= {i, 2'b00};
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    @(posedge core_clk);
    chk(rdv, exp);
  endtask

  task automatic pulse(input int n);
    gen <= 1'b1;
    repeat (n) @(posedge core_clk);
    gen <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic pc(input logic [7:0] exp);
    repeat (3) @(posedge core_clk);
    chk(8'(pwm_out), exp);
  endtask

  // counts output toggles over a burst of source events
  task automatic tg(input logic [7:0] exp, input int n);
    repeat (3) @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    pulse(n);
    chk(8'(togs), exp);
  endtask

  initial
  begin
    #200000;
    errors++;
    $display("watchdog expired");
    give_verdict();
  end

  initial
  begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 8; i++)
      rc(3'(i), rv[i]);
    $display("reset test done");
    wr(3'h2, 8'h08);
    wr(3'h0, 8'h05);
    wr(3'h1, 8'h01);
    rc(3'h0, 8'h05);
    pulse(3);
    rc(3'h0, 8'h02);
    pulse(3);
    rc(3'h0, 8'hFF);
    wr(3'h1, 8'h03);
    wr(3'h0, 8'h05);
    pulse(6);
    rc(3'h0, 8'h05);
    wr(3'h1, 8'h07);
    wr(3'h0, 8'h02);
    pulse(5);
    rc(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h09);
    pulse(3);
    rc(3'h0, 8'h09);
    $display("mode test done");
    wr(3'h1, 8'h09);
    wr(3'h0, 8'h10);
    pulse(4);
    rc(3'h0, 8'h0E);
    wr(3'h2, 8'h38);
    wr(3'h1, 8'h01);
    wr(3'h0, 8'h10);
    pin_en <= 1'b1;
    pulse(3);
    rc(3'h0, 8'h0F);
    wr(3'h2, 8'h28);
    pulse(3);
    rc(3'h0, 8'h0E);
    pin_en <= 1'b0;
    for (int c = 0; c < 8; c++)
    begin
      wr(3'h2, 8'h08 | 8'(c));
      wr(3'h2, 8'(c));
      wr(3'h0, 8'h80);
      pulse(2 << c);
      rc(3'h0, 8'h7F);
    end
    rc(3'h4, 8'hE9);
    wr(3'h4, 8'h55);
    rc(3'h4, rdv);
    $display("source test done");
    wr(3'h2, 8'h08);
    wr(3'h3, 8'h02);
    wr(3'h1, 8'h83);
    wr(3'h0, 8'h04);
    pc(8'h00);
    pulse(2);
    pc(8'h01);
    pulse(2);
    pc(8'h01);
    pulse(1);
    pc(8'h00);
    chk(8'(pwm_pin_select), 8'h01);
    wr(3'h1, 8'hC3);
    pc(8'h01);
    $display("pwm test done");
    wr(3'h1, 8'h00);
    wr(3'h0, 8'hA5);
    for (int b = 0; b < 8; b++)
    begin
      wr(3'h5, 8'h88 | 8'(b));
      repeat (3) @(posedge core_clk);
      chk(8'(buzzer_out), (8'hA5 >> b) & 8'h01);
    end
    wr(3'h1, 8'h01);
    for (int c = 0; c < 8; c++)
    begin
      wr(3'h5, 8'h80 | 8'(c));
      tg(8'h04, 4 << c);
    end
    wr(3'h5, 8'h07);
    tg(8'h00, 16);
    $display("buzzer test done");
    mon_sel <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      ir_pin_data <= ipd[i];
      xtal <= xtl[i];
      wr(3'h6, irc[i]);
      tg(ire[i], irn[i]);
    end
    $display("carrier test done");
    give_verdict();
  end
endmodule // dtp_timer_tb
`default_nettype wire
